// ==== rtl/vrs_consts.svh ====
// constants of the soft-start and fault sequencer: offsets, fields, resets, timing
`ifndef VRS_CONSTS_SVH
`define VRS_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define VRS_OFS_CTRL 8'h00
`define VRS_OFS_TARGET 8'h04
`define VRS_OFS_STATUS 8'h08
`define VRS_OFS_DAC 8'h0C

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define VRS_CTRL_SHED_EN 0
`define VRS_CTRL_SHED_LO 1
`define VRS_CTRL_SHED_HI 3
`define VRS_CTRL_RESET 4'h0
`define VRS_TARGET_RESET 8'h00
`define VRS_STAT_STATE_LO 0
`define VRS_STAT_STATE_HI 3
`define VRS_STAT_THREE_PH 4
`define VRS_STAT_AUX_OFF 5
`define VRS_STAT_OCP 6
`define VRS_STAT_OVP 7
`define VRS_STAT_READY 8
`define VRS_STAT_DRV_LINE 9

// ****************************************************************
// timing, figures in ns at the clock rate in MHz
// ****************************************************************
`define VRS_CLK_MHZ 125
`define VRS_PROBE_NS 2000
`define VRS_MID_NS 1000
`define VRS_DRV_SETTLE_NS 1000
`define VRS_DAC_STEP_NS 80
`define VRS_OCP_DELAY_NS 50000
`define VRS_PROBE_CYC (`VRS_PROBE_NS * `VRS_CLK_MHZ / 1000)
`define VRS_MID_CYC (`VRS_MID_NS * `VRS_CLK_MHZ / 1000)
`define VRS_DRV_SETTLE_CYC (`VRS_DRV_SETTLE_NS * `VRS_CLK_MHZ / 1000)
`define VRS_DAC_STEP_CYC (`VRS_DAC_STEP_NS * `VRS_CLK_MHZ / 1000)
`define VRS_OCP_DELAY_CYC (`VRS_OCP_DELAY_NS * `VRS_CLK_MHZ / 1000)

`endif

// ==== rtl/vrs_pkg.sv ====
// types shared by the sequencer files
package vrs_pkg;

  // sequencer states, codes written out
  typedef enum logic [3:0] {
    VRS_ST_OFF = 4'h0,
    VRS_ST_PROBE = 4'h1,
    VRS_ST_MID = 4'h2,
    VRS_ST_DRV_WAIT = 4'h3,
    VRS_ST_SOFTSTART = 4'h4,
    VRS_ST_RUN = 4'h5,
    VRS_ST_OV_RAMP = 4'h6,
    VRS_ST_OV_HOLD = 4'h7,
    VRS_ST_OC_OFF = 4'h8
  } vrs_state_type;

  typedef logic [7:0] vrs_dac_type;

endpackage

// ==== rtl/vrs_dac_ramp.sv ====
// digital reference ramp: steps the dac code one lsb per tick
`timescale 1ns/1ns
`default_nettype none
`include "vrs_consts.svh"

module vrs_dac_ramp #(
  parameter int unsigned STEP_CYCLES = `VRS_DAC_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic down_i,
  input wire vrs_pkg::vrs_dac_type target_i,
  output vrs_pkg::vrs_dac_type code_o,
  output logic at_target_o,
  output logic at_zero_o
);
  import vrs_pkg::*;

  logic [15:0] tick_q;
  vrs_dac_type code_q;
  wire tick_w = (tick_q == 16'(STEP_CYCLES - 1));
  wire vrs_dac_type goal_w = down_i ? 8'h00 : target_i;
  wire up_w = code_q < goal_w;
  wire dn_w = code_q > goal_w;

  // fixed slew: one step per tick, toward the goal
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !run_i) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_w ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  // code holds at zero while cleared so every restart begins from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      code_q <= 8'h00;
    end else if (run_i && tick_w && up_w) begin
      code_q <= code_q + 8'h01;
    end else if (run_i && tick_w && dn_w) begin
      code_q <= code_q - 8'h01;
    end
  end

  assign code_o = code_q;
  assign at_target_o = (code_q == target_i);
  assign at_zero_o = (code_q == 8'h00);

endmodule // vrs_dac_ramp
`default_nettype wire

// ==== rtl/vrs_sequencer.sv ====
// start-up and fault sequencer of a multiphase buck controller, wishbone slave
`timescale 1ns/1ns
`default_nettype none
`include "vrs_consts.svh"

module vrs_sequencer #(
  parameter int unsigned NPH = 5,
  parameter int unsigned OCP_DELAY_CYCLES = `VRS_OCP_DELAY_CYC,
  parameter int unsigned DAC_STEP_CYCLES = `VRS_DAC_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic enable_i,
  input wire logic vcc_uv_i,
  input wire logic ramp_supply_sense_uv_i,
  input wire logic driver_enable_in_i,
  output logic driver_enable_out_o,
  output logic driver_enable_oe_o,
  input wire logic fourth_phase_output_tied_i,
  input wire logic aux_boot_voltage_pin_tied_i,
  input wire logic [NPH-1:0] pwm_request_i,
  output logic [NPH-1:0] pwm_drive_o,
  output logic [NPH-1:0] pwm_mid_o,
  output logic [NPH-1:0] pwm_high_o,
  output logic [NPH-1:0] pwm_probe_o,
  output logic error_amp_release_o,
  output vrs_pkg::vrs_dac_type dac_code_o,
  input wire logic current_limit_input_low_i,
  input wire logic current_limit_input_high_i,
  output logic [2:0] current_limit_scale_o,
  input wire logic output_uv_i,
  input wire logic output_ov_i,
  input wire logic dynamic_voltage_change_i,
  input wire logic [1:0] current_sense_reference_ov_i,
  output logic regulator_ready_o
);
  import vrs_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // phase 3 is the fourth core phase, the last phase is the aux rail
  function automatic logic phase_used(input int unsigned idx, input logic three_ph, input logic aux_off);
    logic used;
    used = 1'b1;
    if (idx == 3 && three_ph) begin
      used = 1'b0;
    end
    if (idx == NPH - 1 && aux_off) begin
      used = 1'b0;
    end
    return used;
  endfunction

  // true when the state counter has run the given number of cycles
  function automatic logic elapsed(input logic [15:0] cnt, input int unsigned cycles);
    return cnt >= 16'(cycles - 1);
  endfunction

  // ****************************************************************
  // state and storage
  // ****************************************************************
  vrs_state_type state_q;
  vrs_state_type state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] ocp_cnt_q;
  logic [15:0] ocp_cnt_d;
  logic three_ph_q;
  logic aux_off_q;
  logic ocp_flag_q;
  logic ovp_flag_q;
  logic ready_q;
  logic [NPH-1:0] mid_q;
  logic [NPH-1:0] mid_d;
  logic [NPH-1:0] drive_q;
  logic [NPH-1:0] drive_d;
  logic [NPH-1:0] midout_q;
  logic [NPH-1:0] midout_d;
  logic [NPH-1:0] high_q;
  logic [NPH-1:0] high_d;
  logic [NPH-1:0] probe_q;
  logic [NPH-1:0] probe_d;
  logic [NPH-1:0] used_w;
  logic [3:0] ctrl_q;
  vrs_dac_type target_q;
  logic [2:0] scale_q;
  logic ack_q;
  logic [31:0] rdat_q;
  vrs_dac_type dac_code_w;
  logic dac_at_target_w;
  logic dac_at_zero_w;

  // ****************************************************************
  // condition decode
  // ****************************************************************
  wire in_uv_w = vcc_uv_i | ramp_supply_sense_uv_i;
  wire st_fire_w = (state_q == VRS_ST_SOFTSTART) | (state_q == VRS_ST_RUN);
  wire st_drv_w = st_fire_w | (state_q == VRS_ST_DRV_WAIT) | (state_q == VRS_ST_OV_RAMP)
                  | (state_q == VRS_ST_OV_HOLD);
  wire st_fault_w = (state_q == VRS_ST_OV_RAMP) | (state_q == VRS_ST_OV_HOLD) | (state_q == VRS_ST_OC_OFF);
  wire drv_restart_w = st_fire_w & ~driver_enable_in_i;
  wire ocp_delay_w = current_limit_input_low_i & elapsed(ocp_cnt_q, OCP_DELAY_CYCLES);
  wire oc_trip_w = st_fire_w & (current_limit_input_high_i | ocp_delay_w);
  wire ref_ov_w = |current_sense_reference_ov_i;
  wire dac_ov_w = output_ov_i & ~dynamic_voltage_change_i
                  & ((state_q == VRS_ST_RUN) | (state_q == VRS_ST_OV_RAMP));
  wire ov_trip_w = st_fire_w & (ref_ov_w | dac_ov_w);
  wire force_low_w = dac_ov_w | ref_ov_w | (state_q == VRS_ST_OV_HOLD)
                     | (state_q == VRS_ST_OC_OFF);
  wire dac_clear_w = ~(st_fire_w | (state_q == VRS_ST_OV_RAMP) | (state_q == VRS_ST_OV_HOLD));
  wire dac_down_w = (state_q == VRS_ST_OV_RAMP) | (state_q == VRS_ST_OV_HOLD);
  wire [2:0] core_phases_w = three_ph_q ? 3'h3 : 3'h4;

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // faults hold until enable drops, under-voltage only stops a healthy run
  always_comb begin
    state_d = state_q;
    case (state_q)
      VRS_ST_OFF: begin
        if (enable_i && !in_uv_w) begin
          state_d = VRS_ST_PROBE;
        end
      end
      VRS_ST_PROBE: begin
        if (elapsed(cnt_q, `VRS_PROBE_CYC)) begin
          state_d = VRS_ST_MID;
        end
      end
      VRS_ST_MID: begin
        if (elapsed(cnt_q, `VRS_MID_CYC)) begin
          state_d = VRS_ST_DRV_WAIT;
        end
      end
      VRS_ST_DRV_WAIT: begin
        if (elapsed(cnt_q, `VRS_DRV_SETTLE_CYC)) begin
          state_d = driver_enable_in_i ? VRS_ST_SOFTSTART : VRS_ST_MID;
        end
      end
      VRS_ST_SOFTSTART, VRS_ST_RUN: begin
        if (oc_trip_w) begin
          state_d = VRS_ST_OC_OFF;
        end else if (ov_trip_w) begin
          state_d = VRS_ST_OV_RAMP;
        end else if (drv_restart_w) begin
          state_d = VRS_ST_MID;
        end else if (state_q == VRS_ST_SOFTSTART && dac_at_target_w) begin
          state_d = VRS_ST_RUN;
        end
      end
      VRS_ST_OV_RAMP: begin
        if (dac_at_zero_w) begin
          state_d = VRS_ST_OV_HOLD;
        end
      end
      VRS_ST_OV_HOLD, VRS_ST_OC_OFF: begin
        state_d = state_q;
      end
      default: begin
        state_d = VRS_ST_OFF;
      end
    endcase
    if (!enable_i || (in_uv_w && !st_fault_w)) begin
      state_d = VRS_ST_OFF;
    end
  end

  assign cnt_d = (state_d != state_q) ? 16'h0000 : ((cnt_q == 16'hFFFF) ? cnt_q : cnt_q + 16'h0001);
  assign ocp_cnt_d = (st_fire_w && current_limit_input_low_i) ? ocp_cnt_q + 16'h0001 : 16'h0000;

  // state, timers and the configuration caught at the end of probing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= VRS_ST_OFF;
      cnt_q <= 16'h0000;
      ocp_cnt_q <= 16'h0000;
      three_ph_q <= 1'b0;
      aux_off_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ocp_cnt_q <= ocp_cnt_d;
      if (state_q == VRS_ST_PROBE && state_d == VRS_ST_MID) begin
        three_ph_q <= fourth_phase_output_tied_i;
        aux_off_q <= aux_boot_voltage_pin_tied_i;
      end
    end
  end

  // fault flags; set and clear never meet since clear is only in the off state
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == VRS_ST_OFF) begin
      ocp_flag_q <= 1'b0;
      ovp_flag_q <= 1'b0;
    end else begin
      ocp_flag_q <= ocp_flag_q | (state_d == VRS_ST_OC_OFF);
      ovp_flag_q <= ovp_flag_q | (state_d == VRS_ST_OV_RAMP);
    end
  end

  // ready follows the run state and the output under-voltage comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == VRS_ST_RUN) & ~output_uv_i;
    end
  end

  // ****************************************************************
  // phase outputs
  // ****************************************************************

  // mid is set on every entry to the mid stage, cleared by the first pulse
  always_comb begin
    for (int unsigned i = 0; i < NPH; i++) begin
      used_w[i] = phase_used(i, three_ph_q, aux_off_q);
      mid_d[i] = mid_q[i];
      if (state_q == VRS_ST_MID || state_q == VRS_ST_PROBE) begin
        mid_d[i] = 1'b1;
      end else if (st_fire_w && pwm_request_i[i] && !force_low_w) begin
        mid_d[i] = 1'b0;
      end
      // unused phases and probing leave the pin open with its test current
      probe_d[i] = (state_d == VRS_ST_PROBE) | (state_d == VRS_ST_OFF) | ~used_w[i];
      drive_d[i] = ~probe_d[i];
      midout_d[i] = drive_d[i] & mid_d[i] & ~force_low_w
                    & (state_d != VRS_ST_OC_OFF) & (state_d != VRS_ST_OV_HOLD);
      high_d[i] = drive_d[i] & ~mid_d[i] & ~force_low_w & pwm_request_i[i]
                  & ((state_d == VRS_ST_SOFTSTART) | (state_d == VRS_ST_RUN)
                  | (state_d == VRS_ST_OV_RAMP));
    end
  end

  // output controls are registered so the pins never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mid_q <= '1;
      drive_q <= '0;
      midout_q <= '0;
      high_q <= '0;
      probe_q <= '0;
    end else begin
      mid_q <= mid_d;
      drive_q <= drive_d;
      midout_q <= midout_d;
      high_q <= high_d;
      probe_q <= probe_d;
    end
  end

  assign pwm_drive_o = drive_q;
  assign pwm_mid_o = midout_q;
  assign pwm_high_o = high_q;
  assign pwm_probe_o = probe_q;

  // ****************************************************************
  // driver enable, error amplifier and reference
  // ****************************************************************

  // the line is open drain: we drive it high, the driver may pull it low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      driver_enable_oe_o <= 1'b0;
      error_amp_release_o <= 1'b0;
    end else begin
      driver_enable_oe_o <= (state_d == VRS_ST_DRV_WAIT) | (state_d == VRS_ST_SOFTSTART)
                            | (state_d == VRS_ST_RUN) | (state_d == VRS_ST_OV_RAMP)
                            | (state_d == VRS_ST_OV_HOLD);
      error_amp_release_o <= (state_d == VRS_ST_SOFTSTART) | (state_d == VRS_ST_RUN)
                             | (state_d == VRS_ST_OV_RAMP);
    end
  end
  assign driver_enable_out_o = driver_enable_oe_o;

  vrs_dac_ramp #(
    .STEP_CYCLES(DAC_STEP_CYCLES)
  ) u_ramp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(dac_clear_w),
    .run_i(~dac_clear_w),
    .down_i(dac_down_w),
    .target_i(target_q),
    .code_o(dac_code_w),
    .at_target_o(dac_at_target_w),
    .at_zero_o(dac_at_zero_w)
  );
  assign dac_code_o = dac_code_w;

  // limit scale follows the shed count only while shedding is on and the state is soft start or run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scale_q <= 3'h4;
    end else if (ctrl_q[`VRS_CTRL_SHED_EN] && st_fire_w) begin
      scale_q <= ctrl_q[`VRS_CTRL_SHED_HI:`VRS_CTRL_SHED_LO];
    end else begin
      scale_q <= core_phases_w;
    end
  end
  assign current_limit_scale_o = scale_q;
  assign regulator_ready_o = ready_q;

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  wire req_w = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_w = req_w & wb_we_i & wb_sel_i[0];
  wire [31:0] status_w = {22'h000000, driver_enable_in_i, ready_q, ovp_flag_q, ocp_flag_q,
                          aux_off_q, three_ph_q, state_q};
  wire [31:0] read_mux_w = (wb_adr_i == `VRS_OFS_CTRL) ? {28'h0000000, ctrl_q} :
                           (wb_adr_i == `VRS_OFS_TARGET) ? {24'h000000, target_q} :
                           (wb_adr_i == `VRS_OFS_STATUS) ? status_w :
                           (wb_adr_i == `VRS_OFS_DAC) ? {24'h000000, dac_code_w} : 32'h00000000;

  // one wait state: ack a cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req_w;
      rdat_q <= req_w ? read_mux_w : rdat_q;
    end
  end

  // writable fields sit in byte lane 0 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `VRS_CTRL_RESET;
      target_q <= `VRS_TARGET_RESET;
    end else begin
      if (wr_w && wb_adr_i == `VRS_OFS_CTRL) begin
        ctrl_q <= wb_dat_i[3:0];
      end
      if (wr_w && wb_adr_i == `VRS_OFS_TARGET) begin
        target_q <= wb_dat_i[7:0];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule // vrs_sequencer
`default_nettype wire

// ==== dv/vrs_sequencer_monitor.sv ====
// port checker for the soft-start and fault sequencer
`timescale 1ns/1ns
`default_nettype none
module vrs_sequencer_monitor
  import vrs_pkg::*;
#(
  parameter int unsigned NPH = 5,
  parameter int unsigned OCP_DELAY_CYCLES = 20,
  parameter int unsigned DAC_STEP_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic enable_i,
  input wire logic vcc_uv_i,
  input wire logic ramp_supply_sense_uv_i,
  input wire logic driver_enable_in_i,
  input wire logic driver_enable_oe_o,
  input wire logic [NPH-1:0] pwm_drive_o,
  input wire logic [NPH-1:0] pwm_mid_o,
  input wire logic [NPH-1:0] pwm_high_o,
  input wire logic [NPH-1:0] pwm_probe_o,
  input wire logic error_amp_release_o,
  input wire vrs_dac_type dac_code_o,
  input wire logic current_limit_input_low_i,
  input wire logic current_limit_input_high_i,
  input wire logic output_uv_i,
  input wire logic output_ov_i,
  input wire logic dynamic_voltage_change_i,
  input wire logic [1:0] current_sense_reference_ov_i,
  input wire logic regulator_ready_o
);
  logic [15:0] lo_cnt_q;
  wire calm = enable_i && driver_enable_in_i && !vcc_uv_i && !ramp_supply_sense_uv_i && !current_limit_input_high_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // run length of the lower current trip while regulating; slack of three covers the registered path
  always_ff @(posedge clk_i) begin
    if (rst_i || !(current_limit_input_low_i && regulator_ready_o)) lo_cnt_q <= 16'h0000;
    else lo_cnt_q <= lo_cnt_q + 16'h0001;
  end
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer missing or too long");
  property p_en_off; !enable_i |=> !driver_enable_oe_o && !error_amp_release_o && !regulator_ready_o && !(|pwm_drive_o);
  endproperty
  a_en_off: assert property (p_en_off) else $error("enable low did not stop outputs");
  property p_ready_uv; output_uv_i |=> !regulator_ready_o; endproperty
  a_ready_uv: assert property (p_ready_uv) else $error("ready stayed up on low output");
  property p_oc_now; current_limit_input_high_i && regulator_ready_o && !output_ov_i && current_sense_reference_ov_i == 2'h0
    |=> !driver_enable_oe_o && !regulator_ready_o; endproperty
  a_oc_now: assert property (p_oc_now) else $error("upper current trip not immediate");
  property p_oc_delay; lo_cnt_q <= OCP_DELAY_CYCLES + 3; endproperty
  a_oc_delay: assert property (p_oc_delay) else $error("latch-off delay overrun");
  property p_ov_low; output_ov_i && regulator_ready_o && !dynamic_voltage_change_i && calm
    |=> !(|pwm_high_o) && driver_enable_oe_o && !regulator_ready_o; endproperty
  a_ov_low: assert property (p_ov_low) else $error("output over-voltage not acted on");
  property p_ref_ov; (|current_sense_reference_ov_i) && regulator_ready_o && calm
    |=> !(|pwm_high_o) && driver_enable_oe_o && !regulator_ready_o; endproperty
  a_ref_ov: assert property (p_ref_ov) else $error("reference over-voltage not acted on");
  property p_drv_first; $rose(error_amp_release_o) |-> driver_enable_oe_o && $past(driver_enable_oe_o); endproperty
  a_drv_first: assert property (p_drv_first) else $error("amplifier released before driver enable");
  property p_mid_first; $rose(driver_enable_oe_o) |-> |pwm_mid_o; endproperty
  a_mid_first: assert property (p_mid_first) else $error("driver enable without mid level");
  property p_slew; $changed(dac_code_o) && dac_code_o != 8'h00
    |-> dac_code_o - $past(dac_code_o) == 8'h01 || $past(dac_code_o) - dac_code_o == 8'h01; endproperty
  a_slew: assert property (p_slew) else $error("dac moved more than one step");
  property p_enc; !(|(pwm_probe_o & pwm_drive_o)) && !(|(pwm_mid_o & pwm_high_o)); endproperty
  a_enc: assert property (p_enc) else $error("conflicting output controls");
endmodule // vrs_sequencer_monitor

bind vrs_sequencer vrs_sequencer_monitor #(.NPH(NPH), .OCP_DELAY_CYCLES(OCP_DELAY_CYCLES),
  .DAC_STEP_CYCLES(DAC_STEP_CYCLES)) mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .enable_i,
  .vcc_uv_i, .ramp_supply_sense_uv_i, .driver_enable_in_i, .driver_enable_oe_o, .pwm_drive_o, .pwm_mid_o,
  .pwm_high_o, .pwm_probe_o, .error_amp_release_o, .dac_code_o, .current_limit_input_low_i,
  .current_limit_input_high_i, .output_uv_i, .output_ov_i, .dynamic_voltage_change_i,
  .current_sense_reference_ov_i, .regulator_ready_o);
`default_nettype wire

// ==== dv/vrs_gate_driver_model.sv ====
// behavioural gate driver that sinks the shared enable line on its own supply dip
`timescale 1ns/1ns
`default_nettype none
module vrs_gate_driver_model #(
  parameter int unsigned HOLD_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic supply_uv_i,
  input wire logic line_out_i,
  input wire logic line_oe_i,
  output logic line_o
);
  int unsigned hold_q = 0;
  // a short dip still holds the line down long enough for a clean restart
  always_ff @(posedge clk_i) begin
    if (supply_uv_i) hold_q <= HOLD_CYCLES;
    else if (hold_q != 0) hold_q <= hold_q - 1;
  end
  // pull-down wins whenever the controller does not drive it high
  assign line_o = (hold_q == 0) && line_oe_i && line_out_i;
endmodule // vrs_gate_driver_model
`default_nettype wire

// ==== dv/vrs_sequencer_tb_top.sv ====
// self-checking bench for the soft-start and fault sequencer
`timescale 1ns/1ns
`default_nettype none
`include "vrs_consts.svh"
module vrs_sequencer_tb_top;
  import vrs_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic enable_i = 1'h0, vcc_uv_i = 1'h0, ramp_supply_sense_uv_i = 1'h0, drv_uv = 1'h0;
  logic driver_enable_in_i, driver_enable_out_o, driver_enable_oe_o, error_amp_release_o, regulator_ready_o;
  logic fourth_phase_output_tied_i = 1'h0, aux_boot_voltage_pin_tied_i = 1'h0, output_uv_i = 1'h0;
  logic output_ov_i = 1'h0, dynamic_voltage_change_i = 1'h0;
  logic current_limit_input_low_i = 1'h0, current_limit_input_high_i = 1'h0;
  logic [4:0] pwm_request_i = 5'h00, pwm_drive_o, pwm_mid_o, pwm_high_o, pwm_probe_o;
  logic [1:0] current_sense_reference_ov_i = 2'h0;
  logic [2:0] current_limit_scale_o;
  vrs_dac_type dac_code_o;
  int errors = 0, checks_done = 0;
  always #4 clk_i = ~clk_i;
  // short latch-off delay keeps the run small
  vrs_sequencer #(.NPH(5), .OCP_DELAY_CYCLES(20), .DAC_STEP_CYCLES(10)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .enable_i, .vcc_uv_i, .ramp_supply_sense_uv_i,
    .driver_enable_in_i, .driver_enable_out_o, .driver_enable_oe_o, .fourth_phase_output_tied_i,
    .aux_boot_voltage_pin_tied_i, .pwm_request_i, .pwm_drive_o, .pwm_mid_o, .pwm_high_o, .pwm_probe_o,
    .error_amp_release_o, .dac_code_o, .current_limit_input_low_i, .current_limit_input_high_i,
    .current_limit_scale_o, .output_uv_i, .output_ov_i, .dynamic_voltage_change_i,
    .current_sense_reference_ov_i, .regulator_ready_o);
  vrs_gate_driver_model #(.HOLD_CYCLES(40)) drv (.clk_i, .supply_uv_i(drv_uv), .line_out_i(driver_enable_out_o),
    .line_oe_i(driver_enable_oe_o), .line_o(driver_enable_in_i));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      errors++;
      give_verdict();
    end
  endtask
  // polls the status state field with a bounded count
  task automatic wait_st(input vrs_state_type s);
    int n;
    n = 0;
    do begin
      bus(1'h0, `VRS_OFS_STATUS, 32'h0);
      n++;
    end while (rd[3:0] !== s && n < 400);
    chk("state", 32'(s), 32'(rd[3:0]));
    if (rd[3:0] !== s) give_verdict();
  endtask
  task automatic restart;
    @(posedge clk_i);
    enable_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    enable_i <= 1'h1;
    wait_st(VRS_ST_RUN);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int a = 0; a <= 16; a += 4) begin
      bus(1'h0, 8'(a), 32'h0);
      chk("reset_read", 32'h0, rd);
    end
    bus(1'h1, 8'h10, 32'hFF);
    bus(1'h1, `VRS_OFS_TARGET, 32'h4);
    bus(1'h0, `VRS_OFS_TARGET, 32'h0);
    chk("target", 32'h4, rd);
    // a write with lane 0 disabled must leave the target alone
    wb_sel_i <= 4'hE;
    bus(1'h1, `VRS_OFS_TARGET, 32'h9);
    wb_sel_i <= 4'hF;
    bus(1'h0, `VRS_OFS_TARGET, 32'h0);
    chk("target_lane", 32'h4, rd);
    enable_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk("probe", 32'h3E0, 32'({pwm_probe_o, pwm_drive_o}));
    wait_st(VRS_ST_MID);
    chk("mid", 32'h1F, 32'(pwm_mid_o & pwm_drive_o));
    wait_st(VRS_ST_DRV_WAIT);
    chk("oe_release", 32'h2, 32'({driver_enable_oe_o, error_amp_release_o}));
    wait_st(VRS_ST_RUN);
    chk("dac", 32'h4, 32'(dac_code_o));
    pwm_request_i <= 5'h01;
    repeat (3) @(posedge clk_i);
    chk("mid_leave", 32'h1E, 32'(pwm_mid_o));
    pwm_request_i <= 5'h00;
    bus(1'h1, `VRS_OFS_CTRL, 32'h5);
    repeat (3) @(posedge clk_i);
    chk("scale_shed", 32'h2, 32'(current_limit_scale_o));
    bus(1'h1, `VRS_OFS_CTRL, 32'h0);
    output_uv_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("ready_low", 32'h0, 32'(regulator_ready_o));
    output_uv_i <= 1'h0;
    dynamic_voltage_change_i <= 1'h1;
    output_ov_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk("ready_masked", 32'h1, 32'(regulator_ready_o));
    current_sense_reference_ov_i <= 2'h2;
    wait_st(VRS_ST_OV_HOLD);
    chk("ov_hold", 32'hC1, 32'({driver_enable_out_o, driver_enable_oe_o, pwm_high_o, dac_code_o == 8'h00}));
    dynamic_voltage_change_i <= 1'h0;
    output_ov_i <= 1'h0;
    current_sense_reference_ov_i <= 2'h0;
    repeat (10) @(posedge clk_i);
    bus(1'h0, `VRS_OFS_STATUS, 32'h0);
    chk("ov_latch", 32'h287, 32'(rd[9:0]));
    restart();
    output_ov_i <= 1'h1;
    wait_st(VRS_ST_OV_RAMP);
    output_ov_i <= 1'h0;
    restart();
    current_limit_input_high_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("oc_now", 32'h0, 32'(driver_enable_oe_o));
    current_limit_input_high_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    bus(1'h0, `VRS_OFS_STATUS, 32'h0);
    chk("oc_latch", 32'h48, 32'(rd[7:0]));
    restart();
    current_limit_input_low_i <= 1'h1;
    repeat (10) @(posedge clk_i);
    current_limit_input_low_i <= 1'h0;
    wait_st(VRS_ST_RUN);
    current_limit_input_low_i <= 1'h1;
    wait_st(VRS_ST_OC_OFF);
    current_limit_input_low_i <= 1'h0;
    restart();
    drv_uv <= 1'h1;
    @(posedge clk_i);
    drv_uv <= 1'h0;
    wait_st(VRS_ST_MID);
    chk("dac_restart", 32'h0, 32'(dac_code_o));
    wait_st(VRS_ST_RUN);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) vcc_uv_i <= 1'h1;
      else ramp_supply_sense_uv_i <= 1'h1;
      wait_st(VRS_ST_OFF);
      vcc_uv_i <= 1'h0;
      ramp_supply_sense_uv_i <= 1'h0;
      wait_st(VRS_ST_RUN);
    end
    fourth_phase_output_tied_i <= 1'h1;
    aux_boot_voltage_pin_tied_i <= 1'h1;
    restart();
    bus(1'h0, `VRS_OFS_STATUS, 32'h0);
    chk("config", 32'h35, 32'(rd[5:0]));
    chk("scale_three", 32'h3, 32'(current_limit_scale_o));
    chk("unused_probe", 32'h18, 32'(pwm_probe_o));
    give_verdict();
  end
endmodule // vrs_sequencer_tb_top
`default_nettype wire
